// file: sac_sequencer.sv
// Sequencer, register file and trigger logic of the 10-bit converter.
// Assumes an 8-bit peripheral port with one-cycle read and write strobes.
// Functional notes
// - Result high byte top eight, low bits 7:6
// - Result low byte bits 5:0 read zero
// - Results cleared on reset and standby
// - Inputs n and n+4 share one result
// - Group 0 inputs 0-3, group 1 inputs 4-7
// - Control/status cleared on reset and standby
// - End flag set when selected conversions finish
// - End flag cleared by zero after read
// - Interrupt request when flag and enable set
// - Start bit high while converting; zero stops
// - External trigger also sets start bit
// - Single mode clears start after one conversion
// - Multi mode clears start after last channel
// - Scan mode cycles until start bit cleared
// - Multi bit and scan bit select mode
// - Conversion takes 536 or 266 states
// - Single mode converts channel select number
// - Group bit plus count in multi/scan
// - Trigger falling edge only with both enables
// - High byte read latches low byte
// - Next channel starts right after previous
`timescale 1ns/1ps
module sac_sequencer
   import sac_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic standby_i,
   input wire logic [31:0] bus_addr_i,
   input wire logic bus_rd_i,
   input wire logic bus_wr_i,
   input wire logic [7:0] bus_wdata_i,
   output logic [7:0] bus_rdata_o,
   output logic bus_rvalid_o,
   input wire logic ext_trigger_pin_i,
   input wire logic [SAC_RES_W-1:0] analog_result_i,
   output logic [2:0] conv_chan_o,
   output logic end_interrupt_req_o
);
   logic clr;
   sac_state_t state_q;
   sac_state_t state_d;
   logic [2:0] chan_q;
   logic [2:0] chan_d;
   logic conv_end_flag_q;
   logic conv_end_flag_d;
   logic armed_q;
   logic armed_d;
   logic end_irq_enable_q;
   logic end_irq_enable_d;
   logic multi_q;
   logic multi_d;
   logic conv_time_select_q;
   logic conv_time_select_d;
   logic [2:0] chan_sel_q;
   logic [2:0] chan_sel_d;
   logic [1:0] trig_en_q;
   logic [1:0] trig_en_d;
   logic scan_select_bit_q;
   logic scan_select_bit_d;
   logic [7:0] res_hi_q [4];
   logic [7:0] res_hi_d [4];
   logic [1:0] res_lo_q [4];
   logic [1:0] res_lo_d [4];
   logic [1:0] temp_q;
   logic [1:0] temp_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic rvalid_q;
   logic trg_meta_q;
   logic trg_sync_q;
   logic trg_last_q;
   logic busy;
   logic wr_csr;
   logic rd_csr;
   logic wr_trg;
   logic stop_w;
   logic trg_fall;
   logic trg_go;
   logic start_w;
   logic tmr_start;
   logic tmr_done;
   logic last_chan;
   logic in_res;
   logic [2:0] first_chan;

   // Standby behaves as reset for every register of the block except the trigger pin synchronizer and the unreset assertion helpers
   assign clr = srst_i || standby_i;
   assign busy = (state_q == SAC_ST_CONV);
   assign wr_csr = bus_wr_i && (bus_addr_i == SAC_CSR_ADDR);
   assign rd_csr = bus_rd_i && (bus_addr_i == SAC_CSR_ADDR);
   assign wr_trg = bus_wr_i && (bus_addr_i == SAC_TRIG_CTRL_ADDR);
   assign in_res = (bus_addr_i[31:4] == SAC_BASE_ADDR[31:4]) && !bus_addr_i[0];
   assign stop_w = wr_csr && !bus_wdata_i[SAC_CSR_START];
   assign trg_fall = trg_last_q && !trg_sync_q;
   assign trg_go = trg_fall && (trig_en_q == 2'h3);
   assign start_w = !busy && ((wr_csr && bus_wdata_i[SAC_CSR_START]) || trg_go);
   assign last_chan = !multi_q || (chan_q[1:0] == chan_sel_q[1:0]);
   assign first_chan = multi_q ? {chan_sel_q[2], 2'h0} : chan_sel_q;
   // After the last channel only a scan pass re-arms the timer; single and multi leave it idle
   assign tmr_start = start_w
      || (busy && tmr_done && !stop_w && !(last_chan && !(multi_q && scan_select_bit_q)));
   assign bus_rdata_o = rdata_q;
   assign bus_rvalid_o = rvalid_q;
   assign conv_chan_o = chan_q;
   assign end_interrupt_req_o = conv_end_flag_q && end_irq_enable_q;

   sac_conv_timer u_timer
   (
      .ref_clk_i(ref_clk_i),
      .srst_i(clr),
      .start_i(tmr_start),
      .abort_i(busy && stop_w),
      // The start write may carry a new time select, so the timer loads the next value
      .fast_i(conv_time_select_d),
      .done_o(tmr_done)
   );

   always_comb
   begin
      state_d = state_q;
      chan_d = chan_q;
      conv_end_flag_d = conv_end_flag_q;
      armed_d = armed_q;
      end_irq_enable_d = end_irq_enable_q;
      multi_d = multi_q;
      conv_time_select_d = conv_time_select_q;
      chan_sel_d = chan_sel_q;
      trig_en_d = trig_en_q;
      scan_select_bit_d = scan_select_bit_q;
      res_hi_d = res_hi_q;
      res_lo_d = res_lo_q;
      temp_d = temp_q;
      rdata_d = 8'h00;
      if (rd_csr && conv_end_flag_q)
      begin
         armed_d = 1'b1;
      end
      if (wr_csr)
      begin
         end_irq_enable_d = bus_wdata_i[SAC_CSR_IRQ_EN];
         multi_d = bus_wdata_i[SAC_CSR_MULTI];
         conv_time_select_d = bus_wdata_i[SAC_CSR_TIME_SEL];
         chan_sel_d = bus_wdata_i[SAC_CSR_CHAN_MSB:0];
         // Writing one leaves the flag alone
         if (!bus_wdata_i[SAC_CSR_END_FLAG] && armed_q)
         begin
            conv_end_flag_d = 1'b0;
         end
         armed_d = 1'b0;
      end
      if (wr_trg)
      begin
         trig_en_d = bus_wdata_i[SAC_TRG_EN_HI:SAC_TRG_EN_LO];
         scan_select_bit_d = bus_wdata_i[SAC_TRG_SCAN];
      end
      unique case (state_q)
         SAC_ST_IDLE:
         begin
            if (start_w)
            begin
               state_d = SAC_ST_CONV;
               // The start may carry a new mode and channel in the same write
               chan_d = multi_d ? {chan_sel_d[2], 2'h0} : chan_sel_d;
            end
         end
         SAC_ST_CONV:
         begin
            if (stop_w)
            begin
               state_d = SAC_ST_IDLE;
            end
            else if (tmr_done)
            begin
               res_hi_d[chan_q[1:0]] = analog_result_i[9:2];
               res_lo_d[chan_q[1:0]] = analog_result_i[1:0];
               if (last_chan)
               begin
                  // Set wins over a clear in the same cycle
                  conv_end_flag_d = 1'b1;
               end
               if (last_chan && !(multi_q && scan_select_bit_q))
               begin
                  state_d = SAC_ST_IDLE;
               end
               else if (last_chan)
               begin
                  chan_d = first_chan;
               end
               else
               begin
                  chan_d = chan_q + 3'h1;
               end
            end
         end
      endcase
      if (bus_rd_i)
      begin
         if (in_res && !bus_addr_i[1])
         begin
            rdata_d = res_hi_q[bus_addr_i[3:2]];
            temp_d = res_lo_q[bus_addr_i[3:2]];
         end
         else if (in_res)
         begin
            // Low-byte read is served from the latch, not the live result
            rdata_d = {temp_q, 6'h00};
         end
         else if (bus_addr_i == SAC_CSR_ADDR)
         begin
            rdata_d = {conv_end_flag_q, end_irq_enable_q, busy, multi_q,
                       conv_time_select_q, chan_sel_q};
         end
         else if (bus_addr_i == SAC_TRIG_CTRL_ADDR)
         begin
            rdata_d = {trig_en_q, scan_select_bit_q, 2'h0, SAC_TRIG_CONST_ONES};
         end
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (clr)
      begin
         state_q <= SAC_ST_IDLE;
         chan_q <= 3'h0;
         conv_end_flag_q <= SAC_CSR_RESET[SAC_CSR_END_FLAG];
         armed_q <= 1'b0;
         end_irq_enable_q <= SAC_CSR_RESET[SAC_CSR_IRQ_EN];
         multi_q <= SAC_CSR_RESET[SAC_CSR_MULTI];
         conv_time_select_q <= SAC_CSR_RESET[SAC_CSR_TIME_SEL];
         chan_sel_q <= SAC_CSR_RESET[SAC_CSR_CHAN_MSB:0];
         trig_en_q <= SAC_TRIG_CTRL_RESET[SAC_TRG_EN_HI:SAC_TRG_EN_LO];
         scan_select_bit_q <= SAC_TRIG_CTRL_RESET[SAC_TRG_SCAN];
         for (int i = 0; i < 4; i++)
         begin
            res_hi_q[i] <= SAC_RES_RESET;
            res_lo_q[i] <= 2'h0;
         end
         temp_q <= 2'h0;
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         chan_q <= chan_d;
         conv_end_flag_q <= conv_end_flag_d;
         armed_q <= armed_d;
         end_irq_enable_q <= end_irq_enable_d;
         multi_q <= multi_d;
         conv_time_select_q <= conv_time_select_d;
         chan_sel_q <= chan_sel_d;
         trig_en_q <= trig_en_d;
         scan_select_bit_q <= scan_select_bit_d;
         res_hi_q <= res_hi_d;
         res_lo_q <= res_lo_d;
         temp_q <= temp_d;
         rdata_q <= rdata_d;
         rvalid_q <= bus_rd_i;
      end
   end

   // Pin is asynchronous; two stages before the edge detector
   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         trg_meta_q <= 1'b1;
         trg_sync_q <= 1'b1;
         trg_last_q <= 1'b1;
      end
      else
      begin
         trg_meta_q <= ext_trigger_pin_i;
         trg_sync_q <= trg_meta_q;
         trg_last_q <= trg_sync_q;
      end
   end

   // Helper: cycles since the timer was last started
   logic [SAC_CNT_W:0] cyc_q;
   logic rd_lo_q;
   always_ff @(posedge ref_clk_i)
   begin
      cyc_q <= tmr_start ? '0 : cyc_q + (SAC_CNT_W + 1)'(1);
      rd_lo_q <= bus_rd_i && in_res && bus_addr_i[1];
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (clr);

   sequence s_done_kept;
      busy && tmr_done && !stop_w;
   endsequence

   property p_lo_zero;
      rd_lo_q |-> (bus_rdata_o[5:0] == 6'h00);
   endproperty
   a_lo_zero: assert property (p_lo_zero) else $error("low byte bits 5:0 not zero");

   property p_irq;
      $rose(conv_end_flag_q) && end_irq_enable_q |-> end_interrupt_req_o;
   endproperty
   a_irq: assert property (p_irq) else $error("end flag set without request");

   property p_single_end;
      s_done_kept and !multi_q |=> !busy && conv_end_flag_q;
   endproperty
   a_single_end: assert property (p_single_end) else $error("single mode did not end");

   property p_conv_len;
      tmr_done |-> cyc_q == (conv_time_select_q ? SAC_CONV_STATES_FAST - 1
                                                : SAC_CONV_STATES_SLOW - 1);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

   property p_flag_one_write;
      wr_csr && bus_wdata_i[SAC_CSR_END_FLAG] && conv_end_flag_q |=> conv_end_flag_q;
   endproperty
   a_flag_one_write: assert property (p_flag_one_write) else $error("flag cleared by one");

   property p_flag_unarmed;
      wr_csr && !armed_q && conv_end_flag_q |=> conv_end_flag_q;
   endproperty
   a_flag_unarmed: assert property (p_flag_unarmed) else $error("flag cleared unread");

   property p_trig_ignored;
      !busy && trg_fall && trig_en_q != 2'h3 && !bus_wr_i |=> !busy;
   endproperty
   a_trig_ignored: assert property (p_trig_ignored) else $error("disabled trigger started");

   property p_abort;
      busy && stop_w && !$rose(conv_end_flag_q) |=> !busy && $stable(res_hi_q[0])
         && $stable(res_hi_q[1]) && $stable(res_hi_q[2]) && $stable(res_hi_q[3]);
   endproperty
   a_abort: assert property (p_abort) else $error("stop did not discard");

   property p_scan_wrap;
      s_done_kept and last_chan && multi_q && scan_select_bit_q
         |=> busy && chan_q == {chan_sel_q[2], 2'h0};
   endproperty
   a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap");

   property p_next_chan;
      s_done_kept and !last_chan |=> busy && chan_q == $past(chan_q) + 3'h1 ##0 !tmr_done;
   endproperty
   a_next_chan: assert property (p_next_chan) else $error("next channel not started");

   property p_store;
      s_done_kept |=> res_hi_q[$past(chan_q[1:0])] == $past(analog_result_i[9:2]);
   endproperty
   a_store: assert property (p_store) else $error("result stored wrongly");
endmodule : sac_sequencer

// file: sac_pkg.sv
// Shared constants for the successive-approximation converter sequencer.
// Assumes an 8-bit peripheral read/write port and one state per ref_clk_i cycle.
package sac_pkg;
   localparam logic [31:0] SAC_BASE_ADDR = 32'h0400_0080;
   localparam logic [31:0] SAC_RES_A_HI_ADDR = 32'h0400_0080;
   localparam logic [31:0] SAC_RES_A_LO_ADDR = 32'h0400_0082;
   localparam logic [31:0] SAC_RES_B_HI_ADDR = 32'h0400_0084;
   localparam logic [31:0] SAC_RES_B_LO_ADDR = 32'h0400_0086;
   localparam logic [31:0] SAC_RES_C_HI_ADDR = 32'h0400_0088;
   localparam logic [31:0] SAC_RES_C_LO_ADDR = 32'h0400_008A;
   localparam logic [31:0] SAC_RES_D_HI_ADDR = 32'h0400_008C;
   localparam logic [31:0] SAC_RES_D_LO_ADDR = 32'h0400_008E;
   localparam logic [31:0] SAC_CSR_ADDR = 32'h0400_0090;
   localparam logic [31:0] SAC_TRIG_CTRL_ADDR = 32'h0400_0092;

   // Control/status field positions
   localparam int SAC_CSR_END_FLAG = 7;
   localparam int SAC_CSR_IRQ_EN = 6;
   localparam int SAC_CSR_START = 5;
   localparam int SAC_CSR_MULTI = 4;
   localparam int SAC_CSR_TIME_SEL = 3;
   localparam int SAC_CSR_CHAN_MSB = 2;
   // Trigger control field positions
   localparam int SAC_TRG_EN_HI = 7;
   localparam int SAC_TRG_EN_LO = 6;
   localparam int SAC_TRG_SCAN = 5;

   localparam logic [7:0] SAC_CSR_RESET = 8'h00;
   localparam logic [7:0] SAC_TRIG_CTRL_RESET = 8'h07;
   localparam logic [7:0] SAC_RES_RESET = 8'h00;
   localparam logic [2:0] SAC_TRIG_CONST_ONES = 3'h7;

   // Conversion length in peripheral clock states
   localparam int SAC_CONV_STATES_SLOW = 536;
   localparam int SAC_CONV_STATES_FAST = 266;
   localparam int SAC_CNT_W = 10;
   localparam int SAC_RES_W = 10;

   typedef enum logic {SAC_ST_IDLE, SAC_ST_CONV} sac_state_t;
endpackage : sac_pkg

// file: sac_conv_timer.sv
// Timed stand-in for the analog sample and compare core.
// Assumes start_i and abort_i are single-cycle requests from the sequencer.
`timescale 1ns/1ps
module sac_conv_timer
   import sac_pkg::*;
#(
   parameter int SLOW_STATES = SAC_CONV_STATES_SLOW,
   parameter int FAST_STATES = SAC_CONV_STATES_FAST
)
(
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic start_i,
   input wire logic abort_i,
   input wire logic fast_i,
   output logic done_o
);
   logic [SAC_CNT_W-1:0] cnt_q;
   logic [SAC_CNT_W-1:0] cnt_d;
   logic run_q;
   logic run_d;

   assign done_o = run_q && (cnt_q == '0) && !abort_i;

   always_comb
   begin
      cnt_d = cnt_q;
      run_d = run_q;
      if (start_i)
      begin
         // Back-to-back channels restart here in the same cycle as the previous done
         cnt_d = fast_i ? SAC_CNT_W'(FAST_STATES - 1) : SAC_CNT_W'(SLOW_STATES - 1);
         run_d = 1'b1;
      end
      else if (abort_i || done_o)
      begin
         run_d = 1'b0;
      end
      else if (run_q)
      begin
         cnt_d = cnt_q - SAC_CNT_W'(1);
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (srst_i)
      begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         run_q <= run_d;
      end
   end
endmodule : sac_conv_timer

// file: sac_bus_master.sv
// Bus master model for the converter sequencer: one-cycle strobes.
// Assumes the sequencer answers a read with rvalid one cycle later.
`timescale 1ns/1ps
module sac_bus_master
(
   input wire logic ref_clk_i,
   input wire logic [7:0] bus_rdata_i,
   input wire logic bus_rvalid_i,
   output logic [31:0] bus_addr_o,
   output logic bus_rd_o,
   output logic bus_wr_o,
   output logic [7:0] bus_wdata_o
);
   initial
   begin
      bus_addr_o = 32'h0;
      bus_rd_o = 1'h0;
      bus_wr_o = 1'h0;
      bus_wdata_o = 8'h00;
   end

   // Callers change enable and time select only while idle or in the write that stops a scan
   task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] wd,
      output logic [7:0] d, output logic v);
   begin
      @(negedge ref_clk_i);
      bus_addr_o = a;
      bus_wdata_o = wd;
      bus_wr_o = w;
      bus_rd_o = !w;
      @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      d = bus_rdata_i;
      v = bus_rvalid_i;
      bus_rd_o = 1'h0;
      bus_wr_o = 1'h0;
      // Released lines flip so a stale value is never mistaken for a request
      bus_addr_o = ~a;
      bus_wdata_o = ~wd;
   end
   endtask : xfer
endmodule : sac_bus_master

// file: tb_sac_sequencer.sv
// Self-checking bench for the converter sequencer.
// Assumes the bus master model and a stub result made from the channel.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
   $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_sac_sequencer
   import sac_pkg::*;
;
   localparam logic [31:0] CSR = SAC_CSR_ADDR;
   localparam logic [31:0] TRG = SAC_TRIG_CTRL_ADDR;
   localparam int NF = SAC_CONV_STATES_FAST;
   localparam int NS = SAC_CONV_STATES_SLOW;
   logic ref_clk_i = 1'h0;
   logic srst_i = 1'h1;
   logic standby_i = 1'h0;
   logic pin = 1'h1;
   logic [31:0] addr;
   logic rd_s, wr_s, rvalid, irq;
   logic [7:0] wdata, rdata;
   logic [2:0] chan;
   logic [6:0] salt = 7'h00;
   logic [SAC_RES_W-1:0] analog;
   logic [SAC_RES_W-1:0] exp_res [4] = '{default: 10'h000};
   int errors = 0;
   int tests_run = 0;
   int cyc = 0;

   // Stub result names its own channel so misrouting shows
   assign analog = {chan, salt};
   always #2.5 ref_clk_i = ~ref_clk_i;

   sac_sequencer i_sac_sequencer (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
      .standby_i(standby_i), .bus_addr_i(addr), .bus_rd_i(rd_s), .bus_wr_i(wr_s),
      .bus_wdata_i(wdata), .bus_rdata_o(rdata), .bus_rvalid_o(rvalid),
      .ext_trigger_pin_i(pin), .analog_result_i(analog), .conv_chan_o(chan),
      .end_interrupt_req_o(irq));
   sac_bus_master i_sac_bus_master (.ref_clk_i(ref_clk_i), .bus_rdata_i(rdata),
      .bus_rvalid_i(rvalid), .bus_addr_o(addr), .bus_rd_o(rd_s), .bus_wr_o(wr_s),
      .bus_wdata_o(wdata));

   task automatic end_sim();
   begin
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask : end_sim

   // Ceiling well above the longest expected run
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         errors++;
         end_sim();
      end
   end

   function automatic logic [7:0] csr(input logic f, ie, st, mu, fs, input logic [2:0] c);
      return {f, ie, st, mu, fs, c};
   endfunction : csr

   function automatic void done_ch(input logic [2:0] c);
      exp_res[c[1:0]] = {c, salt};
   endfunction : done_ch

   task automatic rd(input logic [31:0] a, output logic [7:0] d);
      logic v;
   begin
      i_sac_bus_master.xfer(a, 1'h0, 8'h00, d, v);
      `CHK(v, 1'h1)
   end
   endtask : rd

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [7:0] x;
      logic v;
   begin
      i_sac_bus_master.xfer(a, 1'h1, d, x, v);
   end
   endtask : wr

   task automatic chk_rd(input logic [31:0] a, input logic [7:0] e);
      logic [7:0] d;
   begin
      rd(a, d);
      `CHK(d, e)
   end
   endtask : chk_rd

   task automatic chk_res();
   begin
      for (int r = 0; r < 4; r++)
      begin
         chk_rd(SAC_BASE_ADDR + 32'(4 * r), exp_res[r][9:2]);
         chk_rd(SAC_BASE_ADDR + 32'(4 * r + 2), {exp_res[r][1:0], 6'h00});
      end
   end
   endtask : chk_res

   task automatic chk_init();
   begin
      for (int r = 0; r < 10; r++)
         chk_rd(SAC_BASE_ADDR + 32'(2 * r), (r == 9) ? 8'h07 : 8'h00);
      chk_rd(32'h0400_0094, 8'h00);
   end
   endtask : chk_init

   // Polls the end flag; returns cycles since the start was taken
   task automatic wait_flag(output int el);
      logic [7:0] d;
      int t0;
   begin
      t0 = cyc;
      d = 8'h00;
      for (int k = 0; k < 1500 && d[7] !== 1'h1; k++)
         rd(CSR, d);
      el = cyc - t0;
   end
   endtask : wait_flag

   task automatic single(input logic [2:0] c, input logic ie, input logic fs);
      int el;
      int n;
   begin
      n = fs ? NF : NS;
      wr(CSR, csr(1'h0, ie, 1'h1, 1'h0, fs, c));
      wait_flag(el);
      `CHK((el >= n) && (el <= n + 5), 1'h1)
      `CHK(irq, ie)
      `CHK(chan, c)
      done_ch(c);
      chk_res();
      chk_rd(CSR, csr(1'h1, ie, 1'h0, 1'h0, fs, c));
      wr(CSR, 8'h00);
      `CHK(irq, 1'h0)
   end
   endtask : single

   task automatic multi(input logic sc, input logic g, input logic [1:0] cnt);
      int el;
      int n;
   begin
      n = NF * (int'(cnt) + 1);
      wr(TRG, {2'h0, sc, 5'h07});
      wr(CSR, csr(1'h0, 1'h0, 1'h1, 1'h1, 1'h1, {g, cnt}));
      wait_flag(el);
      `CHK((el >= n) && (el <= n + 5), 1'h1)
      for (int i = 0; i <= cnt; i++)
         done_ch({g, 2'(i)});
      chk_res();
      chk_rd(CSR, csr(1'h1, 1'h0, sc, 1'h1, 1'h1, {g, cnt}));
      wr(CSR, 8'h00);
      repeat (NF + 4) @(posedge ref_clk_i);
      chk_rd(CSR, 8'h00);
   end
   endtask : multi

   initial
   begin
      logic [7:0] d;
      int s;
      s = $urandom(32'h5f31);
      repeat (16) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      srst_i = 1'h0;
      chk_init();
      $display("test reset values done");
      for (int i = 0; i < 4; i++)
      begin
         salt = 7'($urandom);
         single((i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom), 1'($urandom), 1'($urandom));
      end
      $display("test single done");
      wr(CSR, 8'h28);
      wait_flag(s);
      wr(CSR, 8'h80);
      wr(CSR, 8'h00);
      chk_rd(CSR, 8'h80);
      wr(CSR, 8'h00);
      chk_rd(CSR, 8'h00);
      $display("test flag clear done");
      multi(1'h0, 1'h0, 2'h3);
      rd(SAC_RES_A_HI_ADDR, d);
      chk_rd(SAC_RES_B_HI_ADDR, exp_res[1][9:2]);
      chk_rd(SAC_RES_A_LO_ADDR, {exp_res[1][1:0], 6'h00});
      salt = 7'($urandom);
      multi(1'h0, 1'h1, 2'($urandom));
      multi(1'h1, 1'h1, 2'h2);
      $display("test multi and scan done");
      salt = 7'($urandom);
      wr(CSR, 8'h26);
      repeat (100) @(posedge ref_clk_i);
      wr(CSR, 8'h00);
      repeat (NS + 10) @(posedge ref_clk_i);
      chk_rd(CSR, 8'h00);
      chk_res();
      $display("test abort done");
      wr(TRG, 8'h47);
      wr(CSR, 8'h0D);
      pin = 1'h0;
      repeat (8) @(negedge ref_clk_i);
      chk_rd(CSR, 8'h0D);
      pin = 1'h1;
      wr(TRG, 8'hFF);
      chk_rd(TRG, 8'hE7);
      pin = 1'h0;
      repeat (8) @(negedge ref_clk_i);
      chk_rd(CSR, 8'h2D);
      pin = 1'h1;
      wait_flag(s);
      done_ch(3'h5);
      chk_res();
      chk_rd(CSR, 8'h8D);
      $display("test trigger done");
      standby_i = 1'h1;
      repeat (3) @(negedge ref_clk_i);
      standby_i = 1'h0;
      wr(SAC_RES_A_HI_ADDR, 8'hFF);
      chk_init();
      $display("test standby done");
      end_sim();
   end
endmodule : tb_sac_sequencer
